/* verilog/mif_irq_ctrl.sv */
/*
 * Interrupt request latching and vector dispatch: flag/enable registers,
 * group flags, global enable, fixed priority pick, hardware stack, wake-up.
 * Assumes a classic Wishbone master, single-cycle source event pulses and
 * pin levels synchronous to i_mclk, and a sequencer that offers boundaries.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mif_consts.svh"

// Operation
// RULE_01: extra-pin register flags 5:4, enables 1:0
// RULE_02: timer 0 flags 5:4, enables 1:0
// RULE_03: timer 2 bits only on larger variants
// RULE_04: timer 1 flags 6:4, enables 2:0
// RULE_05: peripheral and serial flags 5:4, enables 1:0
// RULE_06: timer 3 bits only on two largest
// RULE_07: serial port, eeprom, low-voltage flags 6:4
// RULE_08: events set flags regardless of enable
// RULE_09: enable bit gates the vector jump
// RULE_10: global enable low blocks all interrupts
// RULE_11: taking pushes next pc onto stack
// RULE_12: then pc loads the source vector
// RULE_13: return pops the saved pc
// RULE_14: dedicated vectors and shared group vectors
// RULE_15: servicing clears the global enable
// RULE_16: requests while blocked stay latched
// RULE_17: software may re-enable for nesting
// RULE_18: full stack blocks acknowledging requests
// RULE_19: simultaneous requests served by fixed priority
// RULE_20: any flag becoming set wakes device
// RULE_21: software presets flag to avoid wake
// RULE_22: member flag set also sets group flag
// RULE_23: servicing clears group flag, members stay
// RULE_24: two-bit edge select per extra pin
// RULE_25: dedicated sources clear their flag on service
// RULE_26: groups formed one per source register
// RULE_27: vectors and priority order are parameters
module mif_irq_ctrl #(
   parameter int unsigned                 VARIANT    = 3,
   parameter logic [17:0]                 PRIO_ORDER = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0},
   parameter logic [6*`MIF_PC_W-1:0]      VEC_ADDR   = {13'h0018, 13'h0014, 13'h0010,
                                                        13'h000c, 13'h0008, 13'h0004}
) (
   input  wire logic                  i_mclk,
   input  wire logic                  i_sys_rst,
   input  wire mif_pkg::mif_wb_req_t  i_wb,
   output var  logic                  o_wb_ack,
   output var  logic [31:0]           o_wb_dat,
   input  wire mif_pkg::mif_src_evt_t i_src_evt,
   input  wire logic [1:0]            i_ext_pin,
   input  wire mif_pkg::mif_cpu_req_t i_cpu,
   output var  mif_pkg::mif_cpu_ans_t o_cpu,
   output var  logic                  o_stack_full,
   output var  logic                  o_wake,
   output var  logic                  o_global_irq_en
);
   import mif_pkg::*;

   // ****************************************************************
   // implemented bits per register
   // ****************************************************************
   localparam logic [7:0] MASK [5] = '{
      `MIF_MASK_PIN,
      (VARIANT >= `MIF_VAR_TMR2) ? `MIF_MASK_TMRA_L : `MIF_MASK_TMRA_S,    // RULE_03
      `MIF_MASK_TMRB,
      (VARIANT >= `MIF_VAR_TMR3) ? `MIF_MASK_SER_L : `MIF_MASK_SER_S,      // RULE_06
      `MIF_MASK_MISC
   };

   // ****************************************************************
   // state
   // ****************************************************************
   logic [7:0]            ctl [5];
   logic [7:0]            next_ctl [5];
   logic [7:0]            grp;
   logic [7:0]            next_grp;
   logic                  glb_en;
   logic                  next_glb_en;
   logic [3:0]            edge_sel;
   logic [3:0]            next_edge_sel;
   logic [1:0]            pin_prev;
   logic                  wake;
   logic                  next_wake;
   logic [`MIF_PC_W-1:0]  stk [8];
   logic [`MIF_PC_W-1:0]  next_stk [8];
   logic [`MIF_SP_W-1:0]  sp;
   logic [`MIF_SP_W-1:0]  next_sp;
   logic                  full;
   logic                  next_full;
   mif_cpu_ans_t          ans;
   mif_cpu_ans_t          next_ans;
   logic                  ack;
   logic                  next_ack;
   logic [31:0]           rdat;
   logic [31:0]           next_rdat;

   logic [7:0]            set_bits [5];
   logic [3:0]            grp_set;
   logic [3:0]            mem_pend;
   logic [5:0]            req;
   logic [1:0]            pin_hit;
   logic                  hit;
   logic                  take;
   logic                  push_call;
   logic                  pop;
   logic                  wr;
   mif_src_t              sel;

   // ****************************************************************
   // pin edges, events and requests
   // ****************************************************************
   always_comb begin
      logic [1:0] code;
      logic       rise;
      logic       fall;
      code = 2'h0;
      rise = 1'b0;
      fall = 1'b0;
      for (int i = 0; i < 2; i++) begin
         code = edge_sel[2*i +: 2];
         rise = i_ext_pin[i] & ~pin_prev[i];
         fall = ~i_ext_pin[i] & pin_prev[i];
         unique case (code)                                               // RULE_24
            `MIF_EDGE_OFF:  pin_hit[i] = 1'b0;
            `MIF_EDGE_RISE: pin_hit[i] = rise;
            `MIF_EDGE_FALL: pin_hit[i] = fall;
            `MIF_EDGE_BOTH: pin_hit[i] = rise | fall;
         endcase
      end
      // events set flags whatever the enables say
      set_bits[0] = {2'h0, pin_hit, 4'h0} & MASK[0];                      // RULE_08
      set_bits[1] = {i_src_evt.timer_a, 4'h0} & MASK[1];                  // RULE_02
      set_bits[2] = {i_src_evt.timer_b, 4'h0} & MASK[2];                  // RULE_04
      set_bits[3] = {i_src_evt.serial, 4'h0} & MASK[3];                   // RULE_05
      set_bits[4] = {i_src_evt.misc, 4'h0} & MASK[4];                     // RULE_07
      for (int k = 0; k < 4; k++) begin
         grp_set[k]  = |set_bits[k+1];                                    // RULE_22 RULE_26
         mem_pend[k] = |(ctl[k+1][7:4] & ctl[k+1][3:0]);                  // RULE_09
      end
      req[0] = ctl[0][`MIF_FLAG_LSB + `MIF_PIN2_BIT] & ctl[0][`MIF_EN_LSB + `MIF_PIN2_BIT];
      req[1] = ctl[0][`MIF_FLAG_LSB + `MIF_PIN3_BIT] & ctl[0][`MIF_EN_LSB + `MIF_PIN3_BIT];
      req[5:2] = grp[7:4] & grp[3:0] & mem_pend;                          // RULE_14
   end

   // ****************************************************************
   // priority pick and dispatch decision
   // ****************************************************************
   always_comb begin
      hit = 1'b0;
      sel = MIF_SRC_PIN2;
      // walk from lowest to highest so the highest pending one remains
      for (int p = 5; p >= 0; p--) begin
         if (req[PRIO_ORDER[3*p +: 3]]) begin                             // RULE_19 RULE_27
            hit = 1'b1;
            sel = mif_src_t'(PRIO_ORDER[3*p +: 3]);
         end
      end
      // a boundary with a call or return in flight is not used
      take = hit & glb_en & ~full & i_cpu.boundary                        // RULE_10 RULE_18
             & ~i_cpu.call_push & ~i_cpu.return_pop;
      push_call = i_cpu.call_push & ~full;
      pop = i_cpu.return_pop & ~i_cpu.call_push & (sp != 4'h0);
   end

   // ****************************************************************
   // flag, enable and control registers
   // ****************************************************************
   always_comb begin
      logic [7:0] base;
      logic [7:0] clr;
      base = 8'h00;
      clr  = 8'h00;
      wr = i_wb.cyc & i_wb.stb & i_wb.we & ack & i_wb.sel[0];
      for (int r = 0; r < 5; r++) begin
         base = (wr && i_wb.adr == 8'(4 * r)) ? i_wb.dat[7:0] : ctl[r];
         clr = 8'h00;
         if (r == 0 && take && sel == MIF_SRC_PIN2) begin
            clr[`MIF_FLAG_LSB + `MIF_PIN2_BIT] = 1'b1;                    // RULE_25
         end
         if (r == 0 && take && sel == MIF_SRC_PIN3) begin
            clr[`MIF_FLAG_LSB + `MIF_PIN3_BIT] = 1'b1;                    // RULE_25
         end
         // a set in the clearing cycle survives
         next_ctl[r] = ((base & ~clr) | set_bits[r]) & MASK[r];           // RULE_01 RULE_16
      end
      base = (wr && i_wb.adr == `MIF_ADR_GRP) ? i_wb.dat[7:0] : grp;
      clr = 8'h00;
      if (take && sel >= MIF_SRC_MF0) begin
         clr[`MIF_FLAG_LSB + 32'(sel) - 2] = 1'b1;                        // RULE_23
      end
      next_grp = (base & ~clr) | {grp_set, 4'h0};
      next_glb_en = glb_en;
      if (wr && i_wb.adr == `MIF_ADR_CORE) begin
         next_glb_en = i_wb.dat[`MIF_GLB_EN_BIT];                         // RULE_17
      end
      if (take) begin
         next_glb_en = 1'b0;                                              // RULE_15
      end
      next_edge_sel = edge_sel;
      if (wr && i_wb.adr == `MIF_ADR_EDGE) begin
         next_edge_sel = i_wb.dat[`MIF_EDGE_LSB +: 4];
      end
      next_wake = |(grp_set & ~grp[7:4]);
      for (int r = 0; r < 5; r++) begin
         next_wake = next_wake | (|(set_bits[r] & ~ctl[r]));              // RULE_20
      end
   end

   // ****************************************************************
   // hardware stack and sequencer answer
   // ****************************************************************
   always_comb begin
      next_stk = stk;
      next_sp = sp;
      next_ans = ans;
      next_ans.vec_load = take;
      next_ans.ret_load = pop;
      if (take) begin
         next_stk[sp[2:0]] = i_cpu.next_pc;                               // RULE_11
         next_sp = sp + 4'h1;
         next_ans.vec_addr = VEC_ADDR[`MIF_PC_W*32'(sel) +: `MIF_PC_W];  // RULE_12
      end else if (push_call) begin
         next_stk[sp[2:0]] = i_cpu.next_pc;
         next_sp = sp + 4'h1;
      end else if (pop) begin
         next_sp = sp - 4'h1;
         next_ans.ret_addr = stk[3'(sp - 4'h1)];                          // RULE_13
      end
      next_full = (next_sp == `MIF_STK_DEPTH);
   end

   // ****************************************************************
   // wishbone slave
   // ****************************************************************
   always_comb begin
      next_ack = i_wb.cyc & i_wb.stb & ~ack;
      next_rdat = 32'h0000_0000;
      if (next_ack && !i_wb.we) begin
         unique case (i_wb.adr)
            `MIF_ADR_PIN:  next_rdat[7:0] = ctl[0];
            `MIF_ADR_TMRA: next_rdat[7:0] = ctl[1];
            `MIF_ADR_TMRB: next_rdat[7:0] = ctl[2];
            `MIF_ADR_SER:  next_rdat[7:0] = ctl[3];
            `MIF_ADR_MISC: next_rdat[7:0] = ctl[4];
            `MIF_ADR_GRP:  next_rdat[7:0] = grp;
            `MIF_ADR_CORE: next_rdat[`MIF_GLB_EN_BIT] = glb_en;
            `MIF_ADR_EDGE: next_rdat[7:0] = {edge_sel, 4'h0};
            `MIF_ADR_STK:  next_rdat[7:0] = {full, 3'h0, sp};
            default:       next_rdat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         for (int r = 0; r < 5; r++) begin
            ctl[r] <= `MIF_RST_REG;
         end
         for (int s = 0; s < 8; s++) begin
            stk[s] <= '0;
         end
         grp      <= `MIF_RST_REG;
         glb_en   <= 1'b0;
         edge_sel <= `MIF_RST_EDGE;
         pin_prev <= 2'h0;
         wake     <= 1'b0;
         sp       <= 4'h0;
         full     <= 1'b0;
         ans      <= '0;
         ack      <= 1'b0;
         rdat     <= 32'h0000_0000;
      end else begin
         ctl      <= next_ctl;
         stk      <= next_stk;
         grp      <= next_grp;
         glb_en   <= next_glb_en;
         edge_sel <= next_edge_sel;
         pin_prev <= i_ext_pin;
         wake     <= next_wake;
         sp       <= next_sp;
         full     <= next_full;
         ans      <= next_ans;
         ack      <= next_ack;
         rdat     <= next_rdat;
      end
   end

   assign o_wb_ack        = ack;
   assign o_wb_dat        = rdat;
   assign o_cpu           = ans;
   assign o_stack_full    = full;
   assign o_wake          = wake;
   assign o_global_irq_en = glb_en;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   property p_pin_rsv_zero;
      o_wb_ack |-> (ctl[0] & ~`MIF_MASK_PIN) == 8'h00;
   endproperty
   a_pin_rsv_zero: assert property (p_pin_rsv_zero)                      // RULE_01
      else $error("extra-pin register holds a reserved bit");

   property p_tmrb_rsv_zero;
      $rose(o_wb_ack) && $past(i_wb.adr) == `MIF_ADR_TMRB |-> o_wb_dat[7] == 1'b0 && o_wb_dat[3] == 1'b0;
   endproperty
   a_tmrb_rsv_zero: assert property (p_tmrb_rsv_zero)                    // RULE_04
      else $error("timer b register reads a reserved bit as one");

   property p_evt_sets_flag;
      i_src_evt.timer_a[0] |=> ctl[1][4] ##1 (ctl[1][4] || $past(wr));
   endproperty
   a_evt_sets_flag: assert property (p_evt_sets_flag)                    // RULE_08
      else $error("timer 0 event did not latch its flag");

   property p_evt_sets_grp;
      i_src_evt.misc[2] |=> grp[7];
   endproperty
   a_evt_sets_grp: assert property (p_evt_sets_grp)                      // RULE_22
      else $error("member event did not set its group flag");

   property p_take_needs_en;
      take |-> glb_en && (req[sel] == 1'b1) && !full;
   endproperty
   a_take_needs_en: assert property (p_take_needs_en)                    // RULE_10
      else $error("interrupt taken without enables or with full stack");

   sequence s_take;
      take;
   endsequence
   sequence s_vector_out;
      o_cpu.vec_load && !o_global_irq_en && sp == $past(sp) + 4'h1;
   endsequence
   property p_take_push_vector;
      s_take |=> s_vector_out ##1 !o_cpu.vec_load;
   endproperty
   a_take_push_vector: assert property (p_take_push_vector)              // RULE_11
      else $error("take did not push, load the vector and drop the global enable");

   property p_vec_addr;
      take |=> o_cpu.vec_addr == VEC_ADDR[`MIF_PC_W*32'($past(sel)) +: `MIF_PC_W]
               && stk[3'(sp - 4'h1)] == $past(i_cpu.next_pc);
   endproperty
   a_vec_addr: assert property (p_vec_addr)                              // RULE_12
      else $error("wrong vector address or saved pc");

   property p_full_blocks;
      full |-> !take ##1 $stable(sp) || !$past(full) || $past(pop);
   endproperty
   a_full_blocks: assert property (p_full_blocks)                        // RULE_18
      else $error("request acknowledged with a full stack");

   property p_pop_returns;
      pop |=> o_cpu.ret_load && o_cpu.ret_addr == $past(stk[3'(sp - 4'h1)]);
   endproperty
   a_pop_returns: assert property (p_pop_returns)                        // RULE_13
      else $error("return did not pop the saved pc");

   property p_pin_clear;
      take && sel == MIF_SRC_PIN2 && !set_bits[0][4] |=> !ctl[0][4];
   endproperty
   a_pin_clear: assert property (p_pin_clear)                            // RULE_25
      else $error("dedicated flag not cleared on service");

   property p_grp_members_kept;
      take && sel == MIF_SRC_MF0 && !wr |=> (($past(ctl[1][7:4]) & ~ctl[1][7:4]) == 4'h0) && !grp[4]
                                            || $past(grp_set[0]);
   endproperty
   a_grp_members_kept: assert property (p_grp_members_kept)              // RULE_23
      else $error("group service touched member flags or kept group flag");

   property p_wake;
      set_bits[1][5] && !ctl[1][5] |=> o_wake;
   endproperty
   a_wake: assert property (p_wake)                                      // RULE_20
      else $error("new request flag did not raise wake");

endmodule
`default_nettype wire

/* pkg/mif_consts.svh */
/*
 * Constants of the interrupt flag and dispatch block: register offsets,
 * field positions, implemented-bit masks, reset values and stack sizes.
 * Assumes it is included by bare name from the package and the design file.
 */
`ifndef MIF_CONSTS_SVH
`define MIF_CONSTS_SVH

// ****************************************************************
// register byte offsets on the bus
// ****************************************************************
`define MIF_ADR_PIN       8'h00
`define MIF_ADR_TMRA      8'h04
`define MIF_ADR_TMRB      8'h08
`define MIF_ADR_SER       8'h0c
`define MIF_ADR_MISC      8'h10
`define MIF_ADR_GRP       8'h14
`define MIF_ADR_CORE      8'h18
`define MIF_ADR_EDGE      8'h1c
`define MIF_ADR_STK       8'h20

// ****************************************************************
// field layout and implemented bits
// ****************************************************************
`define MIF_FLAG_LSB      4
`define MIF_EN_LSB        0
`define MIF_PIN2_BIT      0
`define MIF_PIN3_BIT      1
`define MIF_GLB_EN_BIT    0
`define MIF_EDGE_LSB      4
`define MIF_STK_FULL_BIT  7
`define MIF_MASK_PIN      8'h33
`define MIF_MASK_TMRA_S   8'h33
`define MIF_MASK_TMRA_L   8'hff
`define MIF_MASK_TMRB     8'h77
`define MIF_MASK_SER_S    8'h33
`define MIF_MASK_SER_L    8'hff
`define MIF_MASK_MISC     8'h77
`define MIF_VAR_TMR2      1
`define MIF_VAR_TMR3      2
`define MIF_RST_REG       8'h00
`define MIF_RST_EDGE      4'h0

// ****************************************************************
// edge select codes, stack and program counter
// ****************************************************************
`define MIF_EDGE_OFF      2'h0
`define MIF_EDGE_RISE     2'h1
`define MIF_EDGE_FALL     2'h2
`define MIF_EDGE_BOTH     2'h3
`define MIF_PC_W          13
`define MIF_SP_W          4
`define MIF_STK_DEPTH     4'h8

`endif

/* pkg/mif_pkg.sv */
/*
 * Types of the interrupt flag and dispatch block: bus request, source
 * events, cpu sequencer request and answer, source identifiers.
 * Assumes mif_consts.svh is on the include path.
 */
`include "mif_consts.svh"

package mif_pkg;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } mif_wb_req_t;

   // each nibble lines up with the flag nibble of its control register
   typedef struct packed {
      logic [3:0] misc;
      logic [3:0] serial;
      logic [3:0] timer_b;
      logic [3:0] timer_a;
   } mif_src_evt_t;

   typedef struct packed {
      logic                 boundary;
      logic                 call_push;
      logic                 return_pop;
      logic [`MIF_PC_W-1:0] next_pc;
   } mif_cpu_req_t;

   typedef struct packed {
      logic                 vec_load;
      logic [`MIF_PC_W-1:0] vec_addr;
      logic                 ret_load;
      logic [`MIF_PC_W-1:0] ret_addr;
   } mif_cpu_ans_t;

   typedef enum logic [2:0] {
      MIF_SRC_PIN2,
      MIF_SRC_PIN3,
      MIF_SRC_MF0,
      MIF_SRC_MF1,
      MIF_SRC_MF2,
      MIF_SRC_MF3
   } mif_src_t;

endpackage

/* tb/mif_cpu_model.sv */
/*
 * Program sequencer model: offers instruction boundaries, pushes on calls,
 * pops on returns, and presents the address of the next instruction.
 * Assumes mif_pkg is compiled first and the block shares its clock.
 */
`timescale 1ns/1ps
`default_nettype none
module mif_cpu_model (
   input  wire logic                  i_mclk,
   input  wire logic                  i_offer,
   output var  mif_pkg::mif_cpu_req_t o_req
);
   import mif_pkg::*;
   logic        push = 1'b0;
   logic        pop  = 1'b0;
   logic        busy = 1'b0;
   logic [12:0] pc   = 13'h0000;
   // ****************************************************************
   // request lines
   // ****************************************************************
   // no boundary while a call or a return occupies the cycle
   assign o_req = '{boundary: i_offer & ~busy, call_push: push, return_pop: pop, next_pc: pc};
   task automatic set_pc(input logic [12:0] v);
      pc <= v;
   endtask
   task automatic call(input logic [12:0] v);
      busy <= 1'b1;
      push <= 1'b1;
      pc   <= v;
      @(posedge i_mclk);
      busy <= 1'b0;
      push <= 1'b0;
   endtask
   task automatic ret();
      busy <= 1'b1;
      pop  <= 1'b1;
      @(posedge i_mclk);
      busy <= 1'b0;
      pop  <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* tb/mif_irq_ctrl_tb.sv */
/*
 * Self-checking bench of the interrupt flag and dispatch block.
 * Assumes mif_pkg, mif_irq_ctrl and mif_cpu_model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module mif_irq_ctrl_tb;
   import mif_pkg::*;
   localparam logic [7:0] ADR [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
   localparam logic [7:0] MSK [5] = '{8'h33, 8'hff, 8'h77, 8'hff, 8'h77};
   logic          mclk    = 1'b0;
   logic          sys_rst = 1'b1;
   logic          offer   = 1'b0;
   mif_wb_req_t   wb      = '0;
   mif_src_evt_t  evt     = '0;
   logic [1:0]    pin     = 2'h0;
   logic          wb_ack;
   logic [31:0]   wb_dat;
   mif_cpu_req_t  cpu_req;
   mif_cpu_ans_t  cpu_ans;
   logic          stk_full;
   logic          wake;
   logic          glb_en;
   logic [12:0]   last_vec = 13'h0000;
   logic [7:0]    r;
   int            mismatches = 0;
   int            cmp_count  = 0;
   int            cycles     = 0;
   int            takes      = 0;
   int            rets       = 0;
   mif_irq_ctrl mif_irq_ctrl_i (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_wb(wb), .o_wb_ack(wb_ack),
      .o_wb_dat(wb_dat), .i_src_evt(evt), .i_ext_pin(pin), .i_cpu(cpu_req), .o_cpu(cpu_ans),
      .o_stack_full(stk_full), .o_wake(wake), .o_global_irq_en(glb_en));
   mif_cpu_model mif_cpu_model_i (.i_mclk(mclk), .i_offer(offer), .o_req(cpu_req));
   // ****************************************************************
   // clock, vector watch and hang guard
   // ****************************************************************
   always #4 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cpu_ans.vec_load === 1'b1) begin
         takes++;
         last_vec = cpu_ans.vec_addr;
      end
      if (cpu_ans.ret_load === 1'b1) begin
         rets++;
      end
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic final_report();
      $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: a, dat: {24'h00_0000, d}};
      @(posedge mclk);
      while (wb_ack !== 1'b1) @(posedge mclk);
      r = wb_dat[7:0];
      wb <= '0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(nm, {24'h00_0000, e}, {24'h00_0000, r});
   endtask
   task automatic pulse(input int b);
      evt <= mif_src_evt_t'(16'h0001 << b);
      @(posedge mclk);
      evt <= '0;
   endtask
   task automatic gap(input int n);
      repeat (n) @(posedge mclk);
   endtask
   function automatic logic [12:0] vec(input int id);
      return 13'h0004 + 13'(4 * id);
   endfunction
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs();
      for (int i = 0; i < 5; i++) begin
         rd("reset value", ADR[i], 8'h00);
         wr(ADR[i], 8'hff);
         rd("implemented bits", ADR[i], MSK[i]);
         wr(ADR[i], 8'h00);
      end
      wr(8'h24, 8'hff);
      rd("unmapped", 8'h24, 8'h00);
      wr(8'h20, 8'hff);
      rd("stack status", 8'h20, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_events();
      int   g;
      logic m;
      for (int b = 0; b < 16; b++) begin
         g = b / 4;
         m = MSK[g+1][b%4+4];
         pulse(b);
         @(negedge mclk);
         chk("wake", {31'h0, m}, {31'h0, wake});
         @(posedge mclk);
         rd("event flag", ADR[g+1], m ? 8'h10 << (b % 4) : 8'h00);
         rd("group flag", 8'h14, m ? 8'h10 << g : 8'h00);
         wr(ADR[g+1], 8'h00);
         wr(8'h14, 8'h00);
      end
      // flags preset by software keep a later event from waking
      wr(8'h04, 8'h10);
      wr(8'h14, 8'h10);
      pulse(0);
      @(negedge mclk);
      chk("wake, preset flag", 0, {31'h0, wake});
      @(posedge mclk);
      wr(8'h04, 8'h00);
      wr(8'h14, 8'h00);
      $display("test events done");
   endtask
   task automatic t_take();
      mif_cpu_model_i.set_pc(13'h0123);
      pulse(0);
      wr(8'h04, 8'h11);
      wr(8'h14, 8'h11);
      offer <= 1'b1;
      gap(5);
      chk("take, global off", 0, takes);
      wr(8'h04, 8'h10);
      wr(8'h18, 8'h01);
      gap(5);
      chk("take, enable off", 0, takes);
      wr(8'h04, 8'h11);
      gap(3);
      chk("takes", 1, takes);
      chk("vector", {19'h0, vec(2)}, {19'h0, last_vec});
      chk("global enable", 0, {31'h0, glb_en});
      rd("group after take", 8'h14, 8'h01);
      rd("member after take", 8'h04, 8'h11);
      rd("stack depth", 8'h20, 8'h01);
      offer <= 1'b0;
      mif_cpu_model_i.ret();
      gap(2);
      chk("return address", 32'h0000_0123, {19'h0, cpu_ans.ret_addr});
      chk("returns", 1, rets);
      wr(8'h04, 8'h00);
      wr(8'h14, 8'h00);
      $display("test take done");
   endtask
   task automatic t_pins();
      for (int c = 0; c < 4; c++) begin
         wr(8'h1c, {c[1:0], c[1:0], 4'h0});
         pin <= 2'h3;
         gap(3);
         rd("rise flags", 8'h00, c[0] ? 8'h30 : 8'h00);
         wr(8'h00, 8'h00);
         pin <= 2'h0;
         gap(3);
         rd("fall flags", 8'h00, c[1] ? 8'h30 : 8'h00);
         wr(8'h00, 8'h00);
      end
      wr(8'h1c, 8'h10);
      pulse(0);
      wr(8'h04, 8'h11);
      wr(8'h14, 8'h11);
      wr(8'h00, 8'h01);
      pin <= 2'h1;
      gap(3);
      offer <= 1'b1;
      wr(8'h18, 8'h01);
      gap(3);
      chk("takes", 2, takes);
      chk("first vector", {19'h0, vec(0)}, {19'h0, last_vec});
      rd("pin flag after take", 8'h00, 8'h01);
      wr(8'h18, 8'h01);
      gap(3);
      chk("takes", 3, takes);
      chk("second vector", {19'h0, vec(2)}, {19'h0, last_vec});
      offer <= 1'b0;
      mif_cpu_model_i.ret();
      gap(1);
      mif_cpu_model_i.ret();
      wr(8'h04, 8'h00);
      wr(8'h14, 8'h00);
      wr(8'h1c, 8'h00);
      $display("test pins done");
   endtask
   task automatic t_stack();
      for (int i = 0; i < 8; i++) begin
         mif_cpu_model_i.call(13'h0200 | i[12:0]);
         gap(1);
      end
      rd("stack status", 8'h20, 8'h88);
      chk("stack full", 1, {31'h0, stk_full});
      wr(8'h00, 8'h11);
      wr(8'h18, 8'h01);
      offer <= 1'b1;
      gap(5);
      chk("take, stack full", 3, takes);
      offer <= 1'b0;
      mif_cpu_model_i.ret();
      offer <= 1'b1;
      gap(3);
      chk("take after pop", 4, takes);
      chk("vector", {19'h0, vec(0)}, {19'h0, last_vec});
      $display("test stack done");
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_regs();
      t_events();
      t_take();
      t_pins();
      t_stack();
      final_report();
   end
endmodule
`default_nettype wire
